/* rtl/fprs_pkg.sv */
// What this block does
// - Lock bit freezes second smoothing register writes
// - Channel slowdown bit makes ramp four times slower
// - Bits 2:0 set local channel ramp rate
// - Smoothing steps duty toward target, never jumps
// - Rate codes give 1,2,3,4,8,12,24,48 steps
// - Timebase bit selects 37.5 s or 52.2 s scale
// - Bit 3 enables local channel smoothing
// - Bits 6:4 set remote two ramp rate
// - Bit 7 enables remote two smoothing
// - Second smoothing register resets to zero
// - Three minimum duty registers reset to half
// - Minimum duty maps linearly onto output duty
// - Automatic mode discards minimum duty writes
// - Hold select picks zero or minimum below threshold
package fprs_pkg;

  localparam logic [7:0] ADDR_CFG6       = 8'h10;
  localparam logic [7:0] ADDR_SMOOTH_A   = 8'h62;
  localparam logic [7:0] ADDR_SMOOTH_B   = 8'h63;
  localparam logic [7:0] ADDR_MIN_DUTY1  = 8'h64;
  localparam logic [7:0] ADDR_MIN_DUTY2  = 8'h65;
  localparam logic [7:0] ADDR_MIN_DUTY3  = 8'h66;
  localparam logic [7:0] ADDR_DUTY_OUT1  = 8'h30;
  localparam logic [7:0] ADDR_DUTY_OUT2  = 8'h31;
  localparam logic [7:0] ADDR_DUTY_OUT3  = 8'h32;

  localparam int LOCAL_RATE_LSB   = 0;
  localparam int LOCAL_EN_BIT     = 3;
  localparam int REMOTE2_RATE_LSB = 4;
  localparam int REMOTE2_EN_BIT   = 7;
  localparam int TIMEBASE_BIT     = 7;
  localparam int SLOW_LOCAL_BIT   = 1;
  localparam int SLOW_REMOTE2_BIT = 2;
  localparam int HOLD_SEL_LSB     = 5;

  localparam logic [7:0] SMOOTH_B_RESET = 8'h00;
  localparam logic [7:0] MIN_DUTY_RESET = 8'h80;
  localparam logic [7:0] CFG6_RESET     = 8'h00;
  localparam logic [2:0] HOLD_SEL_RESET = 3'h0;

  // A full ramp covers 255 duty steps at one step per slot.
  localparam int RAMP_FULL_MS_TB0 = 37500;
  localparam int RAMP_FULL_MS_TB1 = 52200;
  localparam int CLK_KHZ          = 20000;
  localparam int FULL_STEPS       = 255;
  localparam int SLOT_CYC_TB0     = RAMP_FULL_MS_TB0 * CLK_KHZ / FULL_STEPS;
  localparam int SLOT_CYC_TB1     = RAMP_FULL_MS_TB1 * CLK_KHZ / FULL_STEPS;
  localparam int SLOW_FACTOR      = 4;

  function automatic logic [7:0] step_of(input logic [2:0] code);
    unique case (code)
      3'h0: step_of = 8'h01;
      3'h1: step_of = 8'h02;
      3'h2: step_of = 8'h03;
      3'h3: step_of = 8'h04;
      3'h4: step_of = 8'h08;
      3'h5: step_of = 8'h0c;
      3'h6: step_of = 8'h18;
      3'h7: step_of = 8'h30;
    endcase
  endfunction

endpackage

/* rtl/fprs_ramp.sv */
`timescale 1ns/100ps
module fprs_ramp (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic slot_tick,
  fprs_ramp_if.ramp rif
);
  import fprs_pkg::*;

  logic [1:0] pre_q;
  logic [7:0] duty_q;
  logic [7:0] step;
  logic       step_ok;

  assign step    = step_of(rif.rate);
  assign step_ok = slot_tick &&
                   (!rif.slow || pre_q == 2'(SLOW_FACTOR - 1));
  assign rif.duty = duty_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 2'h0;
    end else if (slot_tick) begin
      pre_q <= pre_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      duty_q <= 8'h00;
    end else if (!rif.smooth_en) begin
      duty_q <= rif.target;
    end else if (step_ok) begin
      // Clamp to the target so a large step never overshoots.
      if (rif.target > duty_q) begin
        duty_q <= (rif.target - duty_q > step) ? duty_q + step
                                               : rif.target;
      end else if (rif.target < duty_q) begin
        duty_q <= (duty_q - rif.target > step) ? duty_q - step
                                               : rif.target;
      end
    end
  end
endmodule // fprs_ramp

/* rtl/fprs_ramp_if.sv */
`timescale 1ns/100ps
interface fprs_ramp_if;
  logic [7:0] target;
  logic [2:0] rate;
  logic       smooth_en;
  logic       slow;
  logic [7:0] duty;

  modport ctrl (output target, output rate, output smooth_en,
                output slow, input duty);
  modport ramp (input target, input rate, input smooth_en,
                input slow, output duty);
endinterface // fprs_ramp_if

/* rtl/fprs_tick.sv */
`timescale 1ns/100ps
module fprs_tick #(
  parameter int SLOT_TB0 = fprs_pkg::SLOT_CYC_TB0,
  parameter int SLOT_TB1 = fprs_pkg::SLOT_CYC_TB1,
  parameter int CNT_W    = 22
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic timebase_sel,
  output logic      slot_tick
);
  import fprs_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;

  assign limit = timebase_sel ? CNT_W'(SLOT_TB1 - 1)
                              : CNT_W'(SLOT_TB0 - 1);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q     <= '0;
      slot_tick <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q     <= '0;
      slot_tick <= 1'b1;
    end else begin
      cnt_q     <= cnt_q + 1'b1;
      slot_tick <= 1'b0;
    end
  end
endmodule // fprs_tick

/* rtl/fprs_top.sv */
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module fprs_top #(
  parameter int SLOT_TB0 = fprs_pkg::SLOT_CYC_TB0,
  parameter int SLOT_TB1 = fprs_pkg::SLOT_CYC_TB1
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       config_lock,
  input  wire logic       auto_mode,
  input  wire logic [7:0] local_duty_target,
  input  wire logic [7:0] remote2_duty_target,
  input  wire logic       local_below_min,
  input  wire logic       remote2_below_min,
  input  wire logic [2:0] drive_from_remote2,
  output logic      [7:0] fan_drive_one,
  output logic      [7:0] fan_drive_two,
  output logic      [7:0] fan_drive_three
);
  import fprs_pkg::*;

  logic [7:0] smooth_b_q;
  logic [7:0] cfg6_q;
  logic [2:0] hold_sel_q;
  logic [7:0] min_duty_q [3];
  logic [7:0] drive_q    [3];
  logic       slot_tick;

  fprs_ramp_if rif [3] ();

  fprs_tick #(
    .SLOT_TB0 (SLOT_TB0),
    .SLOT_TB1 (SLOT_TB1),
    .CNT_W    (22)
  ) u_tick (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .timebase_sel (cfg6_q[TIMEBASE_BIT]),
    .slot_tick    (slot_tick)
  );

  // Smoothing settings and lock.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      smooth_b_q <= SMOOTH_B_RESET;
    end else if (reg_wr && reg_addr == ADDR_SMOOTH_B && !config_lock) begin
      smooth_b_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_sel_q <= HOLD_SEL_RESET;
    end else if (reg_wr && reg_addr == ADDR_SMOOTH_A && !config_lock) begin
      hold_sel_q <= reg_wdata[HOLD_SEL_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg6_q <= CFG6_RESET;
    end else if (reg_wr && reg_addr == ADDR_CFG6) begin
      cfg6_q <= reg_wdata;
    end
  end

  // Minimum duty levels; the control loop owns them in automatic mode.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        min_duty_q[i] <= MIN_DUTY_RESET;
      end
    end else if (reg_wr && !auto_mode) begin
      if (reg_addr == ADDR_MIN_DUTY1) begin
        min_duty_q[0] <= reg_wdata;
      end
      if (reg_addr == ADDR_MIN_DUTY2) begin
        min_duty_q[1] <= reg_wdata;
      end
      if (reg_addr == ADDR_MIN_DUTY3) begin
        min_duty_q[2] <= reg_wdata;
      end
    end
  end

  // Per-output ramp setup; each output follows its chosen channel.
  for (genvar g = 0; g < 3; g++) begin : g_out
    logic       use_r2;
    logic       below;
    logic [7:0] tgt;

    assign use_r2 = drive_from_remote2[g];
    assign below  = use_r2 ? remote2_below_min : local_below_min;
    assign tgt    = use_r2 ? remote2_duty_target : local_duty_target;

    // The minimum level is the same 0..255 scale as the output.
    assign rif[g].target = below ? (hold_sel_q[g] ? min_duty_q[g]
                                                  : 8'h00)
                         : (tgt < min_duty_q[g] ? min_duty_q[g]
                                                : tgt);
    assign rif[g].rate = use_r2
        ? smooth_b_q[REMOTE2_RATE_LSB +: 3]
        : smooth_b_q[LOCAL_RATE_LSB +: 3];
    assign rif[g].smooth_en = use_r2 ? smooth_b_q[REMOTE2_EN_BIT]
                                     : smooth_b_q[LOCAL_EN_BIT];
    assign rif[g].slow = use_r2 ? cfg6_q[SLOW_REMOTE2_BIT]
                                : cfg6_q[SLOW_LOCAL_BIT];

    fprs_ramp u_ramp (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .slot_tick (slot_tick),
      .rif       (rif[g])
    );

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        drive_q[g] <= 8'h00;
      end else begin
        drive_q[g] <= rif[g].duty;
      end
    end
  end

  assign fan_drive_one   = drive_q[0];
  assign fan_drive_two   = drive_q[1];
  assign fan_drive_three = drive_q[2];

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CFG6:      reg_rdata <= cfg6_q;
        ADDR_SMOOTH_A:  reg_rdata <= {hold_sel_q, 5'h00};
        ADDR_SMOOTH_B:  reg_rdata <= smooth_b_q;
        ADDR_MIN_DUTY1: reg_rdata <= min_duty_q[0];
        ADDR_MIN_DUTY2: reg_rdata <= min_duty_q[1];
        ADDR_MIN_DUTY3: reg_rdata <= min_duty_q[2];
        ADDR_DUTY_OUT1: reg_rdata <= drive_q[0];
        ADDR_DUTY_OUT2: reg_rdata <= drive_q[1];
        ADDR_DUTY_OUT3: reg_rdata <= drive_q[2];
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // fprs_top

/* verif/fprs_afc_model.sv */
`timescale 1ns/100ps
// Stands in for the control loop that computes new duty targets.
module fprs_afc_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] l_set,
  input  wire logic [7:0] r_set,
  input  wire logic [1:0] b_set,
  output logic      [7:0] l_tgt,
  output logic      [7:0] r_tgt,
  output logic      [1:0] below
);
  always_ff @(posedge sys_clk) begin
    l_tgt <= l_set;
    r_tgt <= r_set;
    below <= b_set;
  end
endmodule // fprs_afc_model

/* verif/fprs_sva.sv */
`timescale 1ns/100ps
module fprs_sva (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       config_lock,
  input wire logic       auto_mode,
  input wire logic [7:0] fan_drive_one
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence rd_at(logic [7:0] a); reg_rd && reg_addr == a; endsequence
  sequence wr_at(logic [7:0] a); reg_wr && reg_addr == a; endsequence
  a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data outside a read cycle");
  a_unmapped_zero: assert property (rd_at(8'h00) |=> !reg_rdata)
    else $error("unmapped read not zero");
  a_smooth_back: assert property (wr_at(8'h63) ##0 !config_lock ##1
    rd_at(8'h63) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("smoothing register write lost");
  // Compares two reads around the write, so no shadow copy is needed.
  a_lock_frozen: assert property (rd_at(8'h63) ##1 wr_at(8'h63)
    ##0 config_lock ##1 rd_at(8'h63) |=> reg_rdata == $past(reg_rdata, 2))
    else $error("locked register changed");
  a_auto_frozen: assert property (rd_at(8'h64) ##1 wr_at(8'h64)
    ##0 auto_mode ##1 rd_at(8'h64) |=> reg_rdata == $past(reg_rdata, 2))
    else $error("minimum duty changed in automatic mode");
  a_min_back: assert property (wr_at(8'h64) ##0 !auto_mode ##1
    rd_at(8'h64) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("minimum duty write lost");
  a_cfg6_back: assert property (wr_at(8'h10) ##1 rd_at(8'h10)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("timebase register write lost");
  // The outputs are unknown until the first edge under reset clears them.
  a_reset_idle: assert property (disable iff (1'b0)
    !reset_n ##1 !reset_n |-> fan_drive_one == 8'h00)
    else $error("fan drive not idle in reset");
  c_locked_wr: cover property (wr_at(8'h63) ##0 config_lock);
  c_auto_wr: cover property (wr_at(8'h64) ##0 auto_mode);
  c_big_step: cover property (fan_drive_one == 8'h30);
endmodule // fprs_sva

bind fprs_top fprs_sva i_fprs_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_lock(config_lock),
  .auto_mode(auto_mode), .fan_drive_one(fan_drive_one));

/* verif/testbench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
  import fprs_pkg::*;
  localparam int T0 = 20;
  localparam int T1 = 28;
  logic       sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       config_lock = 1'b0, auto_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, l_set = 8'h00;
  logic [7:0] r_set = 8'h00, l_tgt, r_tgt, reg_rdata, d1, d2, d3;
  logic [1:0] b_set = 2'h0, below;
  logic [2:0] sel = 3'h0;
  logic [7:0] p;
  logic       ok;
  logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                            8'h08, 8'h0c, 8'h18, 8'h30};
  logic [7:0] cfgs [3] = '{8'h00, 8'h80, 8'h02};
  int         gaps [3] = '{T0, T1, SLOW_FACTOR * T0};
  int         err_count = 0, n_checks = 0, cyc = 0, n, k, c;

  fprs_afc_model i_fprs_afc_model (.sys_clk(sys_clk), .l_set(l_set),
    .r_set(r_set), .b_set(b_set), .l_tgt(l_tgt), .r_tgt(r_tgt),
    .below(below));
  fprs_top #(.SLOT_TB0(T0), .SLOT_TB1(T1)) i_fprs_top (.sys_clk(sys_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .config_lock(config_lock), .auto_mode(auto_mode),
    .local_duty_target(l_tgt), .remote2_duty_target(r_tgt),
    .local_below_min(below[0]), .remote2_below_min(below[1]),
    .drive_from_remote2(sel), .fan_drive_one(d1), .fan_drive_two(d2),
    .fan_drive_three(d3));

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  task automatic chk_rd(input logic [7:0] e);
    @(negedge sys_clk);
    `CHK(reg_rdata, e)
  endtask
  // Read data stand for one cycle only, so they are taken mid-cycle.
  task automatic rd(input logic [7:0] a, e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge sys_clk);
    fork chk_rd(e); join_none
  endtask
  task automatic idle(input int m);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    repeat (m) @(posedge sys_clk);
  endtask
  task automatic gap(output int g);
    logic [7:0] o;
    o = d1;
    g = 0;
    idle(0);
    do begin @(negedge sys_clk); g++; end while (d1 === o && g < 500);
    @(posedge sys_clk);
  endtask

  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin err_count++; stop_test(); end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(8'h63, 8'h00);
    for (k = 0; k < 3; k++) rd(8'h64 + 8'(k), 8'h80);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    wr(8'h63, 8'ha5);
    rd(8'h63, 8'ha5);
    config_lock <= 1'b1;
    rd(8'h63, 8'ha5);
    wr(8'h63, 8'h5a);
    rd(8'h63, 8'ha5);
    config_lock <= 1'b0;
    auto_mode <= 1'b1;
    rd(8'h64, 8'h80);
    wr(8'h64, 8'h11);
    rd(8'h64, 8'h80);
    auto_mode <= 1'b0;
    for (k = 0; k < 3; k++) wr(8'h66 - 8'(k), 8'h00);
    rd(8'h64, 8'h00);
    wr(8'h10, 8'h82);
    rd(8'h10, 8'h82);
    for (c = 0; c < 11; c++) begin
      wr(8'h63, 8'h00);
      l_set <= 8'h00;
      wr(8'h10, c < 8 ? 8'h00 : cfgs[c-8]);
      idle(4);
      `CHK(d1, 8'h00)
      wr(8'h63, c < 8 ? 8'h08 | 8'(c) : 8'h08);
      l_set <= 8'hc8;
      gap(n);
      if (c < 8) begin
        `CHK(d1, steps[c])
        for (k = 0; k < 250 && d1 !== 8'hc8; k++) begin
          p = d1;
          gap(n);
          `CHK(d1 <= 8'hc8, 1'b1)
          ok = d1 - p == steps[c] || d1 == 8'hc8 && d1 - p < steps[c];
          `CHK(ok, 1'b1)
          `CHK(n, T0)
        end
        `CHK(d1, 8'hc8)
      end else begin
        gap(n);
        `CHK(n, gaps[c-8])
      end
    end
    wr(8'h10, 8'h00);
    wr(8'h63, 8'h00);
    l_set <= 8'h00;
    idle(4);
    wr(8'h63, 8'hf0);
    sel <= 3'h2;
    r_set <= 8'h60;
    idle(1);
    for (k = 0; k < 100 && d2 === 8'h00; k++) @(negedge sys_clk);
    `CHK(d2, 8'h30)
    @(posedge sys_clk);
    wr(8'h63, 8'h00);
    sel <= 3'h0;
    wr(8'h64, 8'h40);
    wr(8'h62, 8'h20);
    rd(8'h62, 8'h20);
    b_set <= 2'h1;
    l_set <= 8'hc0;
    idle(4);
    `CHK(d1, 8'h40)
    wr(8'h62, 8'h00);
    idle(4);
    `CHK({d1, d3}, 16'h0000)
    b_set <= 2'h0;
    l_set <= 8'h10;
    idle(4);
    `CHK(d1, 8'h40)
    rd(8'h30, 8'h40);
    idle(1);
    stop_test();
  end
endmodule // testbench
